// file: logic/sld_ctrl.sv
// segment display driver control: registers, frame timing and drive levels
// Functional notes
// - duty field: 00 half, 01 third, 1x quarter duty.
// - bias bit 7: 0 half bias, 1 third bias levels.
// - all drive timing comes from the sub-clock only.
// - control bit 4 switches the display on.
// - display off: all backplanes and frontplanes at ground.
// - bit 2 selects waveform type A or B; bit 3 unused.
// - rate 00: slot of 256, 172 or 128 sub-clocks per duty.
// - rate 01: slot of 280, 188 or 140 sub-clocks per duty.
// - rate 10: slot of 304, 204 or 152 sub-clocks per duty.
// - rate 11: slot of 232, 156 or 116 sub-clocks per duty.
// - pointer bits 7..5 read zero; bits 4..0 address memory.
// - addresses 00..1F map to frontplanes 0..31.
// - window bits 3..0 are pixels for backplanes 0..3; 7..4 unused.
// - pump clock is sub-clock divided by 1, 4, 8 or 16.
module sld_ctrl
  import sld_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sub_clk,
  input wire logic [sld_pkg::SLD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sld_pkg::SLD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2*sld_pkg::SLD_COMS-1:0] backplane,
  output logic [2*sld_pkg::SLD_SEGS-1:0] frontplane,
  output logic pump_clk
);
  import sld_pkg::*;

  sld_ram_if ram ();
  sld_ram u_ram (
    .aclk(aclk),
    .aresetn(aresetn),
    .ram(ram.mem)
  );

  logic [7:0] display_control;
  logic [4:0] display_memory_pointer;
  logic [7:0] system_booster_pll_control;

  // ---- axi write path
  logic aw_held;
  logic w_held;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic do_write;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 6'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_lane0 <= s_axi_wstrb[0];
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !do_write;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !do_write;
    end
  end

  logic addr_ok_w;
  assign addr_ok_w = (aw_addr == SLD_OFF_CTRL) || (aw_addr == SLD_OFF_PTR)
    || (aw_addr == SLD_OFF_WIN) || (aw_addr == SLD_OFF_PUMP) || (aw_addr == SLD_OFF_STAT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SLD_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok_w ? SLD_RESP_OKAY : SLD_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  logic wr_en;
  assign wr_en = do_write && w_lane0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      display_control <= SLD_CTRL_RST;
      system_booster_pll_control <= SLD_PUMP_RST;
      display_memory_pointer <= 5'h00;
    end
    else if (wr_en)
    begin
      if (aw_addr == SLD_OFF_CTRL)
        display_control <= w_data[7:0] & SLD_CTRL_MASK;
      if (aw_addr == SLD_OFF_PUMP)
        system_booster_pll_control <= w_data[7:0] & SLD_PUMP_MASK;
      if (aw_addr == SLD_OFF_PTR)
        display_memory_pointer <= w_data[4:0];
    end
  end

  // window write goes to the location the pointer holds
  assign ram.wr = wr_en && (aw_addr == SLD_OFF_WIN);
  assign ram.addr = display_memory_pointer;
  assign ram.wdata = w_data[3:0];

  // ---- axi read path
  logic [5:0] ar_addr;
  logic rd_pend;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      rd_pend <= 1'b0;
      ar_addr <= 6'h00;
    end
    else
    begin
      s_axi_arready <= !rd_pend && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        rd_pend <= 1'b1;
        ar_addr <= s_axi_araddr;
      end
      else if (rd_pend)
        rd_pend <= 1'b0;
    end
  end

  logic [4:0] slot_idx;
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ar_addr)
      SLD_OFF_CTRL: rd_val = {24'h000000, display_control};
      SLD_OFF_PTR: rd_val = {27'h0000000, display_memory_pointer};
      SLD_OFF_WIN: rd_val = {28'h0000000, ram.rdata};
      SLD_OFF_PUMP: rd_val = {24'h000000, system_booster_pll_control};
      SLD_OFF_STAT: rd_val = {27'h0000000, slot_idx};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SLD_RESP_OKAY;
    end
    else if (rd_pend)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? SLD_RESP_OKAY : SLD_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // sub-clock sampling; frame timing and the pump counter run on its rising edges, pump code 00 passes the sampled level
  logic sub_m;
  logic sub_s;
  logic sub_d;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sub_m <= 1'b0;
      sub_s <= 1'b0;
      sub_d <= 1'b0;
    end
    else
    begin
      sub_m <= sub_clk;
      sub_s <= sub_m;
      sub_d <= sub_s;
    end
  end
  logic fs_tick;
  assign fs_tick = sub_s && !sub_d;

  // ---- frame timing
  logic on;
  logic [1:0] duty;
  logic [1:0] rate;
  assign on = display_control[SLD_ON_BIT];
  assign duty = {display_control[SLD_DUTY_HI], display_control[SLD_DUTY_LO]};
  assign rate = {display_control[SLD_RATE_HI], display_control[SLD_RATE_LO]};

  logic [8:0] slot_len;
  logic [1:0] n_com;
  always_comb
  begin
    case (duty)
      2'b00:
      begin
        slot_len = SLD_SLOT_D2[rate];
        n_com = 2'd1;
      end
      2'b01:
      begin
        slot_len = SLD_SLOT_D3[rate];
        n_com = 2'd2;
      end
      default:
      begin
        slot_len = SLD_SLOT_D4[rate];
        n_com = 2'd3;
      end
    endcase
  end

  sld_state_e state;
  logic [8:0] slot_cnt;
  logic [1:0] com_idx;
  logic phase;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= SLD_IDLE;
      slot_cnt <= 9'h000;
      com_idx <= 2'b00;
      phase <= 1'b0;
    end
    else
    begin
      case (state)
        SLD_IDLE:
        begin
          slot_cnt <= 9'h000;
          com_idx <= 2'b00;
          phase <= 1'b0;
          if (on)
            state <= SLD_RUN;
        end
        SLD_RUN:
        begin
          if (!on)
            state <= SLD_IDLE;
          else if (fs_tick)
          begin
            // type A flips polarity each half slot, type B each frame
            if (slot_cnt >= slot_len - 9'd1)
            begin
              slot_cnt <= 9'h000;
              if (com_idx >= n_com)
              begin
                com_idx <= 2'b00;
                if (display_control[SLD_SHAPE_BIT])
                  phase <= !phase;
              end
              else
                com_idx <= com_idx + 2'd1;
            end
            else
            begin
              slot_cnt <= slot_cnt + 9'd1;
              if (!display_control[SLD_SHAPE_BIT] && slot_cnt == (slot_len >> 1) - 9'd1)
                phase <= !phase;
              else if (!display_control[SLD_SHAPE_BIT] && slot_cnt == slot_len - 9'd2)
                phase <= !phase;
            end
          end
        end
        default: state <= SLD_IDLE;
      endcase
    end
  end
  assign slot_idx = {1'b0, state == SLD_RUN, phase, com_idx};

  // ---- drive levels: rail index 0..3; half bias uses 0, mid (mapped to rail 1), 3
  logic bias3;
  assign bias3 = display_control[SLD_BIAS_BIT];
  logic [SLD_SEGS*4-1:0] pix;
  logic [4:0] scan_ptr;
  assign ram.scan_addr = scan_ptr;
  // local copy refreshed one location per clock; a pixel change shows within 32 clocks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scan_ptr <= 5'h00;
      pix <= '0;
    end
    else
    begin
      scan_ptr <= scan_ptr + 5'h01;
      pix[scan_ptr*4 +: 4] <= ram.scan_data;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || state != SLD_RUN)
    begin
      backplane <= '0;
      frontplane <= '0;
    end
    else
    begin
      for (int c = 0; c < SLD_COMS; c++)
      begin
        if (c > n_com)
          backplane[c*2 +: 2] <= bias3 ? 2'd1 : 2'd1; // unused backplane sits mid-rail
        else if (c == com_idx)
          backplane[c*2 +: 2] <= phase ? 2'd0 : 2'd3;
        else
          backplane[c*2 +: 2] <= bias3 ? (phase ? 2'd2 : 2'd1) : 2'd1;
      end
      for (int s = 0; s < SLD_SEGS; s++)
      begin
        if (pix[s*4 + com_idx])
          frontplane[s*2 +: 2] <= phase ? 2'd3 : 2'd0;
        else
          frontplane[s*2 +: 2] <= bias3 ? (phase ? 2'd1 : 2'd2) : (phase ? 2'd0 : 2'd3);
      end
    end
  end

  // pump clock divider
  logic [3:0] pump_cnt;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pump_cnt <= 4'h0;
      pump_clk <= 1'b0;
    end
    else
    begin
      if (fs_tick)
        pump_cnt <= pump_cnt + 4'h1;
      // bit n of a tick counter has a period of 2^(n+1) sub-clocks
      case (system_booster_pll_control[SLD_PUMP_HI:SLD_PUMP_LO])
        2'b00: pump_clk <= sub_s;
        2'b01: pump_clk <= pump_cnt[1];
        2'b10: pump_clk <= pump_cnt[2];
        default: pump_clk <= pump_cnt[3];
      endcase
    end
  end

  a_off_ground: assert property (@(posedge aclk) disable iff (!aresetn)
    !on |=> ##1 (backplane == '0 && frontplane == '0))
    else $error("outputs not grounded while off");
  a_ptr_width: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && ar_addr == SLD_OFF_PTR |-> s_axi_rdata[31:5] == '0)
    else $error("pointer high bits not zero");
  a_win_high: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && ar_addr == SLD_OFF_WIN |-> s_axi_rdata[31:4] == '0)
    else $error("window high bits not zero");
  a_off_state: assert property (@(posedge aclk) disable iff (!aresetn)
    !on |=> state == SLD_IDLE)
    else $error("timing still running while off");
  a_ptr_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && aw_addr == SLD_OFF_PTR |=> display_memory_pointer == $past(w_data[4:0]))
    else $error("pointer write lost");
  a_slot_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    state == SLD_RUN && on && !fs_tick |=> $stable(com_idx))
    else $error("backplane stepped without a sub-clock edge");
endmodule : sld_ctrl

// file: logic/sld_pkg.sv
// constants for the segment display driver control block
package sld_pkg;
  localparam int SLD_ADDR_W = 6;
  localparam logic [5:0] SLD_OFF_CTRL = 6'h00;
  localparam logic [5:0] SLD_OFF_PTR = 6'h04;
  localparam logic [5:0] SLD_OFF_WIN = 6'h08;
  localparam logic [5:0] SLD_OFF_PUMP = 6'h0C;
  localparam logic [5:0] SLD_OFF_STAT = 6'h10;
  localparam int SLD_BIAS_BIT = 7;
  localparam int SLD_DUTY_HI = 6;
  localparam int SLD_DUTY_LO = 5;
  localparam int SLD_ON_BIT = 4;
  localparam int SLD_SHAPE_BIT = 2;
  localparam int SLD_RATE_HI = 1;
  localparam int SLD_RATE_LO = 0;
  localparam int SLD_PUMP_HI = 2;
  localparam int SLD_PUMP_LO = 1;
  localparam logic [7:0] SLD_CTRL_MASK = 8'hF7;
  localparam logic [7:0] SLD_PTR_MASK = 8'h1F;
  localparam logic [7:0] SLD_WIN_MASK = 8'h0F;
  localparam logic [7:0] SLD_PUMP_MASK = 8'h06;
  localparam logic [7:0] SLD_CTRL_RST = 8'h00;
  localparam logic [7:0] SLD_PUMP_RST = 8'h00;
  localparam int SLD_COMS = 4;
  localparam int SLD_SEGS = 32;
  localparam logic [1:0] SLD_RESP_OKAY = 2'b00;
  localparam logic [1:0] SLD_RESP_SLVERR = 2'b10;
  // slot lengths in sub-clock periods, index = frame-rate code
  localparam logic [8:0] SLD_SLOT_D2 [4] = '{9'd256, 9'd280, 9'd304, 9'd232};
  localparam logic [8:0] SLD_SLOT_D3 [4] = '{9'd172, 9'd188, 9'd204, 9'd156};
  localparam logic [8:0] SLD_SLOT_D4 [4] = '{9'd128, 9'd140, 9'd152, 9'd116};
  // drive levels: index of the supply rail, 0 = ground, 3 = full
  typedef logic [1:0] sld_lvl_t;
  typedef enum logic [1:0] {SLD_IDLE = 2'b00, SLD_RUN = 2'b01} sld_state_e;
endpackage : sld_pkg

// file: logic/sld_ram_if.sv
// display memory access bundle between the register slave and the memory
interface sld_ram_if;
  logic wr;
  logic [4:0] addr;
  logic [3:0] wdata;
  logic [3:0] rdata;
  logic [4:0] scan_addr;
  logic [3:0] scan_data;
  modport ctrl (output wr, output addr, output wdata, input rdata,
    output scan_addr, input scan_data);
  modport mem (input wr, input addr, input wdata, output rdata,
    input scan_addr, output scan_data);
endinterface : sld_ram_if

// file: logic/sld_ram.sv
// 32 x 4 display memory with a cpu port and a scan read port
module sld_ram
  import sld_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sld_ram_if.mem ram
);
  logic [3:0] mem [SLD_SEGS];

  // one location per frontplane
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < SLD_SEGS; i++)
        mem[i] <= 4'h0;
    end
    else if (ram.wr)
      mem[ram.addr] <= ram.wdata;
  end

  assign ram.rdata = mem[ram.addr];
  assign ram.scan_data = mem[ram.scan_addr];
endmodule : sld_ram

// file: tb/sld_glass_model.sv
// passive glass stand-in watching the backplane and frontplane drive lines
module sld_glass_model
(
  input wire logic aclk,
  input wire logic clr,
  input wire logic [7:0] backplane,
  input wire logic [63:0] frontplane,
  output logic dark,
  output logic lit_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // the glass only loads the lines, so it observes and never drives
  assign dark = (backplane === 8'h00) && (frontplane === 64'h0);
  // sticky so a short non-ground burst between bench samples is not missed
  always @(posedge aclk)
  begin
    lit_seen <= clr ? 1'b0 : (lit_seen | !dark);
  end
endmodule : sld_glass_model

// file: tb/segment_lcd_driver_control_tb_top.sv
// self-checking bench for the segment display driver control block
module segment_lcd_driver_control_tb_top;
  import sld_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, sub_clk, clr, dark, lit_seen, pump_clk;
  logic [SLD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] backplane;
  logic [63:0] frontplane;
  logic [2:0] sc;
  logic [3:0] mem [32];
  int errors, tests_run, i, n;

  sld_ctrl i_dut (.aclk, .aresetn, .sub_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .backplane, .frontplane, .pump_clk);
  sld_glass_model i_glass (.aclk, .clr, .backplane, .frontplane, .dark, .lit_seen);

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // sub-clock at one eighth of aclk keeps frame and pump spans short
  always @(posedge aclk)
  begin
    sc <= sc + 3'h1;
    sub_clk <= sc[2];
  end

  function automatic logic [31:0] pump_exp(input int code);
    return 32'((code == 0 ? 1 : 2 << code) * 8);
  endfunction : pump_exp

  function automatic logic [31:0] slot_exp(input int dsel, input int rsel);
    logic [8:0] len;
    len = dsel == 0 ? SLD_SLOT_D2[rsel] : (dsel == 1 ? SLD_SLOT_D3[rsel] : SLD_SLOT_D4[rsel]);
    return 32'(len) * 32'd8;
  endfunction : slot_exp

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t value got %h exp %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t resp got %b exp %b", $time, got, exp);
    end
  endtask : chk_resp

  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t line state got %b exp %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic axw(input logic [5:0] a, input logic [31:0] dv, input logic [3:0] s,
    output logic [1:0] rs);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= dv;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && s_axi_awready)
      begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready)
      begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid)
      @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [5:0] a, output logic [31:0] dv, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid)
      @(posedge aclk);
    dv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axr

  task automatic wr(input logic [5:0] a, input logic [31:0] dv);
    logic [1:0] rs;
    axw(a, dv, 4'hF, rs);
    chk_resp(rs, SLD_RESP_OKAY);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] dv;
    logic [1:0] rs;
    axr(a, dv, rs);
    chk_resp(rs, SLD_RESP_OKAY);
    chk_data(dv, exp);
  endtask : rd_chk

  // aclk edges from one pump rise to the next, skipping the first partial period
  task automatic pump_period(output int cnt);
    logic p;
    int k;
    k = 0;
    cnt = 0;
    p = pump_clk;
    while (k < 3)
    begin
      @(posedge aclk);
      if (pump_clk && !p)
        k++;
      if (k == 2)
        cnt++;
      p = pump_clk;
    end
  endtask : pump_period

  // aclk edges between two backplane steps, skipping the first partial slot
  task automatic slot_period(output int cnt);
    logic [7:0] p;
    int k;
    k = 0;
    cnt = 0;
    p = backplane;
    while (k < 3)
    begin
      @(posedge aclk);
      if (backplane !== p)
        k++;
      if (k == 2)
        cnt++;
      p = backplane;
    end
  endtask : slot_period

  task automatic results();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (95000) @(posedge aclk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  initial
  begin
    errors = 0;
    tests_run = 0;
    sc = 3'h0;
    sub_clk = 1'b0;
    aresetn = 1'b0;
    clr = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    v = $urandom(32'h5522);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(SLD_OFF_CTRL, 32'h0);
    rd_chk(SLD_OFF_PUMP, 32'h0);
    chk_flag(dark, 1'b1);
    $display("reset values done");
    repeat (8)
    begin
      v = $urandom;
      wr(SLD_OFF_CTRL, v);
      rd_chk(SLD_OFF_CTRL, v & {24'h0, SLD_CTRL_MASK});
      wr(SLD_OFF_PUMP, v);
      rd_chk(SLD_OFF_PUMP, v & {24'h0, SLD_PUMP_MASK});
    end
    axw(SLD_OFF_CTRL, ~v, 4'hE, r);
    rd_chk(SLD_OFF_CTRL, v & {24'h0, SLD_CTRL_MASK});
    axw(6'h14, 32'hFF, 4'hF, r);
    chk_resp(r, SLD_RESP_SLVERR);
    axr(6'h3C, d, r);
    chk_resp(r, SLD_RESP_SLVERR);
    $display("register access done");
    for (i = 0; i < 32; i++)
    begin
      wr(SLD_OFF_PTR, 32'({$urandom, 5'(i)}));
      mem[i] = 4'($urandom);
      wr(SLD_OFF_WIN, 32'({$urandom, mem[i]}));
    end
    for (i = 31; i >= 0; i--)
    begin
      wr(SLD_OFF_PTR, 32'(i));
      rd_chk(SLD_OFF_PTR, 32'(i));
      rd_chk(SLD_OFF_WIN, {28'h0, mem[i]});
    end
    $display("display memory done");
    for (i = 0; i < 4; i++)
    begin
      wr(SLD_OFF_CTRL, {24'h0, i[0], 2'(i), 1'b1, 1'b0, i[1], 2'(i)});
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      n = 0;
      while (!lit_seen && n < 6000)
      begin
        @(posedge aclk);
        n++;
      end
      chk_flag(lit_seen, 1'b1);
    end
    $display("display on done");
    for (i = 0; i < 4; i++)
    begin
      wr(SLD_OFF_PUMP, 32'(i << 1));
      pump_period(n);
      chk_data(32'(n), pump_exp(i));
    end
    $display("pump divider done");
    for (i = 0; i < 4; i++)
    begin
      wr(SLD_OFF_CTRL, {24'h0, 1'b0, 2'(i), 1'b1, 1'b0, 1'b1, 2'(i)});
      slot_period(n);
      chk_data(32'(n), slot_exp(i, i));
    end
    $display("frame timing done");
    wr(SLD_OFF_CTRL, 32'({$urandom, 8'h00}) | 32'hEF);
    repeat (4) @(posedge aclk);
    repeat (200)
    begin
      @(posedge aclk);
      chk_flag(dark, 1'b1);
    end
    $display("display off done");
    results();
  end
endmodule : segment_lcd_driver_control_tb_top
